/* File: hdl/spcl_consts.svh */
`ifndef SPCL_CONSTS_SVH
`define SPCL_CONSTS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define SPCL_REG_CTRL        5'h00
`define SPCL_REG_ADV         5'h04
`define SPCL_REG_STRAP       5'h1f

// ****************************************************************
// Field positions
// ****************************************************************
`define SPCL_CTRL_SPEED      13
`define SPCL_CTRL_AN         12
`define SPCL_CTRL_DUPLEX     8
`define SPCL_ADV_100FD       8
`define SPCL_ADV_100HD       7
`define SPCL_ADV_10FD        6
`define SPCL_ADV_10HD        5
`define SPCL_STRAP_FEF       0
`define SPCL_STRAP_FIBER     1
`define SPCL_STRAP_DONE      2

// ****************************************************************
// Reset values and write masks
// ****************************************************************
`define SPCL_CTRL_RST        16'h3100
`define SPCL_ADV_RST         16'h01e1
`define SPCL_ADV_WMASK       16'h01e0
`define SPCL_STRAP_WMASK     16'h0001
`define SPCL_DATA_ZERO       16'h0000

`endif

/* File: hdl/spcl_pkg.sv */
package spcl_pkg;

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef enum logic [1:0]
   {
      SPCL_ST_CAPTURE = 2'b01,
      SPCL_ST_RUN     = 2'b10
   } spcl_state_type;

   typedef struct packed
   {
      logic speed;
      logic duplex;
      logic autoneg;
   } spcl_pins_type;

   typedef struct packed
   {
      logic [4:0]  addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } spcl_bus_type;

   typedef struct packed
   {
      logic speed_100;
      logic full_duplex;
      logic autoneg_en;
      logic far_end_fault_en;
      logic fiber_mode;
   } spcl_cfg_type;

   typedef struct packed
   {
      spcl_state_type st;
      logic [15:0]    ctrl;
      logic [15:0]    adv;
      logic           fef;
      logic           fiber;
      logic [15:0]    rdata;
      spcl_pins_type  pin_out;
   } spcl_regs_type;

endpackage

/* File: hdl/spcl_strap_latch.sv */
`timescale 1ns/100ps
`include "spcl_consts.svh"
// What this block does
// - Speed strap loads control bit 13 at capture.
// - Speed strap also sets advertised speed capability.
// - High strap means 100Mbps, low means 10Mbps.
// - Speed meaning applies only in copper mode.
// - Fiber mode: speed strap sets far-end fault enable.
// - Duplex strap loads bit 8, high half duplex.
// - Autoneg strap loads bit 12, high enables.
// - Fiber mode forces auto-negotiation disabled.
// - Pins are pulled inputs in reset and until capture, outputs after.
// - Straps captured once, in the first enabled cycle after reset release.
module spcl_strap_latch
#(
   parameter bit FIBER_CAPABLE = 1'b1
)
(
   input  wire logic                   mclk_i,
   input  wire logic                   rstn_i,
   input  wire logic                   ce_i,
   input  wire logic                   fiber_mode_select_i,
   input  wire spcl_pkg::spcl_pins_type strap_pin_i,
   output      spcl_pkg::spcl_pins_type strap_pin_o,
   output      logic [2:0]             strap_pin_oe_o,
   output      logic                   strap_pull_up_o,
   input  wire spcl_pkg::spcl_pins_type pin_data_i,
   input  wire spcl_pkg::spcl_bus_type  bus_i,
   output      logic [15:0]            rdata_o,
   output      spcl_pkg::spcl_cfg_type  cfg_o
);
   import spcl_pkg::*;

   // ****************************************************************
   // Helper functions
   // ****************************************************************
   function automatic logic [15:0] merge_bits
   (
      input logic [15:0] old_v,
      input logic [15:0] new_v,
      input logic [15:0] mask
   );
      merge_bits = (old_v & ~mask) | (new_v & mask);
   endfunction

   function automatic logic [15:0] read_reg
   (
      input logic [4:0]    addr,
      input spcl_regs_type s
   );
      logic [15:0] v;
      v = `SPCL_DATA_ZERO;
      case (addr)
         `SPCL_REG_CTRL:
         begin
            v = s.ctrl;
         end
         `SPCL_REG_ADV:
         begin
            v = s.adv;
         end
         `SPCL_REG_STRAP:
         begin
            v[`SPCL_STRAP_FEF]   = s.fef;
            v[`SPCL_STRAP_FIBER] = s.fiber;
            v[`SPCL_STRAP_DONE]  = (s.st == SPCL_ST_RUN);
         end
         default:
         begin
            v = `SPCL_DATA_ZERO;
         end
      endcase
      read_reg = v;
   endfunction

   // ****************************************************************
   // State
   // ****************************************************************
   spcl_regs_type cur_r;
   spcl_regs_type cur_nxt;
   logic          fiber_now;

   assign fiber_now = FIBER_CAPABLE && fiber_mode_select_i;

   // The capture happens in the first enabled cycle after reset release, so
   // the flops under asynchronous reset only ever load constants.
   always_comb
   begin
      cur_nxt = cur_r;
      if (ce_i)
      begin
         cur_nxt.rdata = bus_i.rd ? read_reg(bus_i.addr, cur_r) : `SPCL_DATA_ZERO;
         case (cur_r.st)
            SPCL_ST_CAPTURE:
            begin
               cur_nxt.fiber = fiber_now;
               cur_nxt.ctrl[`SPCL_CTRL_DUPLEX] = strap_pin_i.duplex;
               if (fiber_now)
               begin
                  cur_nxt.fef = strap_pin_i.speed;
                  cur_nxt.ctrl[`SPCL_CTRL_AN] = 1'b0;
               end
               else
               begin
                  cur_nxt.ctrl[`SPCL_CTRL_SPEED] = strap_pin_i.speed;
                  cur_nxt.adv[`SPCL_ADV_100FD] = strap_pin_i.speed;
                  cur_nxt.adv[`SPCL_ADV_100HD] = strap_pin_i.speed;
                  cur_nxt.ctrl[`SPCL_CTRL_AN] = strap_pin_i.autoneg;
               end
               cur_nxt.st = SPCL_ST_RUN;
            end
            SPCL_ST_RUN:
            begin
               cur_nxt.pin_out = pin_data_i;
               // Only software writes change the latched bits from here on.
               if (bus_i.wr)
               begin
                  case (bus_i.addr)
                     `SPCL_REG_CTRL:
                     begin
                        cur_nxt.ctrl = bus_i.wdata;
                     end
                     `SPCL_REG_ADV:
                     begin
                        cur_nxt.adv = merge_bits(cur_r.adv, bus_i.wdata,
                                                 `SPCL_ADV_WMASK);
                     end
                     `SPCL_REG_STRAP:
                     begin
                        cur_nxt.fef = merge_bits({15'h0000, cur_r.fef}, bus_i.wdata,
                                                 `SPCL_STRAP_WMASK) != `SPCL_DATA_ZERO;
                     end
                     default:
                     begin
                        cur_nxt.fef = cur_r.fef;
                     end
                  endcase
               end
            end
            default:
            begin
               cur_nxt.st = SPCL_ST_CAPTURE;
            end
         endcase
      end
   end

   always_ff @(posedge mclk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         cur_r.st      <= SPCL_ST_CAPTURE;
         cur_r.ctrl    <= `SPCL_CTRL_RST;
         cur_r.adv     <= `SPCL_ADV_RST;
         cur_r.fef     <= 1'b1;
         cur_r.fiber   <= 1'b0;
         cur_r.rdata   <= `SPCL_DATA_ZERO;
         cur_r.pin_out <= '0;
      end
      else
      begin
         cur_r <= cur_nxt;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   // Pins stay released with pull-ups on until the straps are taken, so the
   // board resistors, or the pull-ups where none is fitted, decide the captured level.
   assign strap_pin_oe_o        = {3{cur_r.st == SPCL_ST_RUN}};
   assign strap_pull_up_o       = (cur_r.st != SPCL_ST_RUN);
   assign strap_pin_o           = cur_r.pin_out;
   assign rdata_o               = cur_r.rdata;
   assign cfg_o.speed_100       = cur_r.ctrl[`SPCL_CTRL_SPEED];
   assign cfg_o.full_duplex     = ~cur_r.ctrl[`SPCL_CTRL_DUPLEX];
   assign cfg_o.autoneg_en      = cur_r.ctrl[`SPCL_CTRL_AN];
   assign cfg_o.far_end_fault_en = cur_r.fef;
   assign cfg_o.fiber_mode      = cur_r.fiber;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!rstn_i);

   // Reset is part of the capture test because an attempt that starts on the
   // releasing edge still sees the state from before that edge.
   sequence s_capture_copper;
      rstn_i && cur_r.st == SPCL_ST_CAPTURE && ce_i && !fiber_now;
   endsequence

   sequence s_capture_fiber;
      rstn_i && cur_r.st == SPCL_ST_CAPTURE && ce_i && fiber_now;
   endsequence

   sequence s_capture_any;
      rstn_i && cur_r.st == SPCL_ST_CAPTURE && ce_i;
   endsequence

   sequence s_idle_run;
      cur_r.st == SPCL_ST_RUN && !(ce_i && bus_i.wr);
   endsequence

   sequence s_settled;
      s_idle_run [*2];
   endsequence

   speed_latch_a : assert property (
      s_capture_copper |=> cur_r.ctrl[`SPCL_CTRL_SPEED] == $past(strap_pin_i.speed))
      else $error("Speed strap not loaded into control bit.");

   adv_latch_a : assert property (
      s_capture_copper |=> cur_r.adv[`SPCL_ADV_100FD] == $past(strap_pin_i.speed)
                           && cur_r.adv[`SPCL_ADV_100HD] == $past(strap_pin_i.speed))
      else $error("Speed strap not loaded into advertisement.");

   speed_out_a : assert property (
      s_capture_copper ##1 s_settled |-> cfg_o.speed_100 == $past(strap_pin_i.speed, 2))
      else $error("Speed output does not follow the strap.");

   fiber_speed_a : assert property (
      s_capture_fiber |=> $stable(cur_r.ctrl[`SPCL_CTRL_SPEED]))
      else $error("Speed bit changed in fiber mode.");

   fef_latch_a : assert property (
      s_capture_fiber |=> cfg_o.far_end_fault_en == $past(strap_pin_i.speed))
      else $error("Far-end fault enable not latched.");

   duplex_latch_a : assert property (
      s_capture_any |=> cfg_o.full_duplex == !$past(strap_pin_i.duplex))
      else $error("Duplex strap not latched.");

   an_latch_a : assert property (
      s_capture_copper |=> cfg_o.autoneg_en == $past(strap_pin_i.autoneg))
      else $error("Autoneg strap not latched.");

   fiber_an_a : assert property (
      s_capture_fiber |=> !cfg_o.autoneg_en && cfg_o.fiber_mode)
      else $error("Autoneg not forced off in fiber mode.");

   pin_dir_a : assert property (
      (cur_r.st == SPCL_ST_CAPTURE |-> strap_pin_oe_o == 3'b000 && strap_pull_up_o)
      and (cur_r.st == SPCL_ST_RUN |-> strap_pin_oe_o == 3'b111 && !strap_pull_up_o))
      else $error("Strap pin direction wrong.");

   cap_once_a : assert property (
      cur_r.st == SPCL_ST_RUN |=> cur_r.st == SPCL_ST_RUN)
      else $error("Capture repeated outside reset.");

   hold_cfg_a : assert property (
      s_idle_run |=> $stable(cur_r.ctrl) && $stable(cur_r.adv) && $stable(cur_r.fef))
      else $error("Latched bits changed without a write.");

   ctrl_write_a : assert property (
      cur_r.st == SPCL_ST_RUN && ce_i && bus_i.wr && bus_i.addr == `SPCL_REG_CTRL
      |=> cur_r.ctrl == $past(bus_i.wdata))
      else $error("Control write not taken.");

   read_data_a : assert property (
      ce_i && bus_i.rd && bus_i.addr == `SPCL_REG_CTRL |=> rdata_o == $past(cur_r.ctrl))
      else $error("Read data wrong or late.");

   // ****************************************************************
   // Register port, capture and pin assertions
   // ****************************************************************
   read_adv_a : assert property (
      ce_i && bus_i.rd && bus_i.addr == `SPCL_REG_ADV |=> rdata_o == $past(cur_r.adv))
      else $error("Advertisement read data wrong.");

   read_strap_a : assert property (
      ce_i && bus_i.rd && bus_i.addr == `SPCL_REG_STRAP
      |=> rdata_o[`SPCL_STRAP_FEF] == $past(cur_r.fef)
          && rdata_o[`SPCL_STRAP_FIBER] == $past(cur_r.fiber)
          && rdata_o[`SPCL_STRAP_DONE] == $past(cur_r.st == SPCL_ST_RUN))
      else $error("Strap register read data wrong.");

   read_zero_a : assert property (
      ce_i && bus_i.rd && bus_i.addr != `SPCL_REG_CTRL && bus_i.addr != `SPCL_REG_ADV
      && bus_i.addr != `SPCL_REG_STRAP |=> rdata_o == `SPCL_DATA_ZERO)
      else $error("Unmapped read not zero.");

   read_idle_a : assert property (
      ce_i && !bus_i.rd |=> rdata_o == `SPCL_DATA_ZERO)
      else $error("Read data stood longer than one cycle.");

   adv_write_a : assert property (
      cur_r.st == SPCL_ST_RUN && ce_i && bus_i.wr && bus_i.addr == `SPCL_REG_ADV
      |=> (cur_r.adv & `SPCL_ADV_WMASK) == ($past(bus_i.wdata) & `SPCL_ADV_WMASK)
          && (cur_r.adv & ~`SPCL_ADV_WMASK) == ($past(cur_r.adv) & ~`SPCL_ADV_WMASK))
      else $error("Advertisement write not taken as masked.");

   fef_write_a : assert property (
      cur_r.st == SPCL_ST_RUN && ce_i && bus_i.wr && bus_i.addr == `SPCL_REG_STRAP
      |=> cfg_o.far_end_fault_en == $past(bus_i.wdata[`SPCL_STRAP_FEF])
          && $stable(cur_r.fiber))
      else $error("Far-end fault write not taken.");

   cap_write_a : assert property (
      s_capture_any |=> (cur_r.ctrl & 16'hceff) == ($past(cur_r.ctrl) & 16'hceff))
      else $error("Capture changed control bits that are not straps.");

   capture_done_a : assert property (
      s_capture_any |=> cur_r.st == SPCL_ST_RUN)
      else $error("Capture did not finish in one enabled cycle.");

   fiber_adv_a : assert property (
      s_capture_fiber |=> $stable(cur_r.adv))
      else $error("Advertisement changed in fiber mode.");

   copper_fef_a : assert property (
      s_capture_copper |=> $stable(cur_r.fef) && !cfg_o.fiber_mode)
      else $error("Far-end fault enable changed in copper mode.");

   fiber_flag_a : assert property (
      s_capture_any |=> cfg_o.fiber_mode == $past(fiber_now))
      else $error("Fiber mode not latched.");

   duplex_out_a : assert property (
      s_capture_any ##1 s_settled |-> cfg_o.full_duplex == !$past(strap_pin_i.duplex, 2))
      else $error("Duplex output does not follow the strap.");

   an_out_a : assert property (
      s_capture_copper ##1 s_settled |-> cfg_o.autoneg_en == $past(strap_pin_i.autoneg, 2))
      else $error("Autoneg output does not follow the strap.");

   fiber_hold_a : assert property (
      s_capture_fiber ##1 s_settled |-> !cfg_o.autoneg_en && cfg_o.speed_100)
      else $error("Fiber mode settings did not hold.");

   fiber_keep_a : assert property (
      cur_r.st == SPCL_ST_RUN |=> $stable(cur_r.fiber))
      else $error("Fiber mode changed after capture.");

   state_freeze_a : assert property (
      rstn_i && !ce_i |=> $stable(cur_r))
      else $error("State moved while the clock enable was low.");

   pin_follow_a : assert property (
      cur_r.st == SPCL_ST_RUN && ce_i |=> strap_pin_o == $past(pin_data_i))
      else $error("Pin output does not follow its data.");

   pin_quiet_a : assert property (
      cur_r.st == SPCL_ST_CAPTURE |-> strap_pin_o == '0)
      else $error("Pin output data moved before capture.");

   pull_hold_a : assert property (
      cur_r.st == SPCL_ST_CAPTURE && !ce_i |=> strap_pull_up_o && strap_pin_oe_o == 3'b000)
      else $error("Pins left input mode while capture waited.");

endmodule // spcl_strap_latch

/* File: tb/spcl_board_model.sv */
`timescale 1ns/100ps
// ****************************************************************
// Board strap resistors and the shared pin wires
// ****************************************************************
module spcl_board_model
(
   input  wire logic                    mclk_i,
   input  wire spcl_pkg::spcl_pins_type pin_o_i,
   input  wire logic [2:0]              oe_i,
   input  wire logic                    pull_up_i,
   input  wire logic [2:0]              res_fit_i,
   input  wire logic [2:0]              res_val_i,
   output      spcl_pkg::spcl_pins_type wire_o
);
   import spcl_pkg::*;
   logic [2:0] last_r;
   logic [2:0] lvl;
   logic [2:0] po;
   assign po = pin_o_i;
   // The MAC side stays off the wires during reset, so only resistors and pull-ups act.
   // A wire nobody holds flips each cycle rather than keep a stale level.
   always_comb
   begin
      for (int b = 0; b < 3; b++)
      begin
         if (oe_i[b])
            lvl[b] = po[b];
         else if (res_fit_i[b])
            lvl[b] = res_val_i[b];
         else if (pull_up_i)
            lvl[b] = 1'b1;
         else
            lvl[b] = ~last_r[b];
      end
   end
   always_ff @(posedge mclk_i)
      last_r <= lvl;
   assign wire_o = lvl;
endmodule // spcl_board_model

/* File: tb/testbench.sv */
`timescale 1ns/100ps
`include "spcl_consts.svh"
// ****************************************************************
// Strap capture bench
// ****************************************************************
module testbench;
   import spcl_pkg::*;
   logic          mclk_i = 1'b0;
   logic          rstn_i = 1'b0;
   logic          ce_i = 1'b1;
   logic          fib = 1'b0;
   logic [2:0]    oe, fit = 3'h7, val = 3'h7;
   logic          pu;
   logic [15:0]   d, w, ea;
   logic [15:0]   rdata;
   spcl_pins_type pin_o, pin_w, pin_data = '0;
   spcl_bus_type  bus = '0;
   spcl_cfg_type  cfg;
   int            mismatches = 0, checked = 0;
   integer        seed = 32'h707c_bd2a;
   always #2.5 mclk_i = ~mclk_i;
   spcl_strap_latch dut_u (.mclk_i(mclk_i), .rstn_i(rstn_i), .ce_i(ce_i),
      .fiber_mode_select_i(fib), .strap_pin_i(pin_w), .strap_pin_o(pin_o),
      .strap_pin_oe_o(oe), .strap_pull_up_o(pu), .pin_data_i(pin_data),
      .bus_i(bus), .rdata_o(rdata), .cfg_o(cfg));
   spcl_board_model brd_u (.mclk_i(mclk_i), .pin_o_i(pin_o), .oe_i(oe),
      .pull_up_i(pu), .res_fit_i(fit), .res_val_i(val), .wire_o(pin_w));
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      checked++;
      if (g !== e)
      begin
         mismatches++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic rd(input logic [4:0] a, output logic [15:0] q);
      @(posedge mclk_i);
      bus <= '{addr:a, wdata:16'h0000, wr:1'b0, rd:1'b1};
      @(posedge mclk_i);
      bus.rd <= 1'b0;
      #1 q = rdata;
      @(posedge mclk_i);
   endtask
   task automatic wr(input logic [4:0] a, input logic [15:0] q);
      @(posedge mclk_i);
      bus <= '{addr:a, wdata:q, wr:1'b1, rd:1'b0};
      @(posedge mclk_i);
      bus.wr <= 1'b0;
   endtask
   function automatic logic [15:0] e_ctrl(logic f, logic [2:0] v);
      e_ctrl = `SPCL_CTRL_RST;
      e_ctrl[8] = v[1];
      e_ctrl[13] = f | v[2];
      e_ctrl[12] = ~f & v[0];
   endfunction
   function automatic logic [15:0] e_adv(logic f, logic [2:0] v);
      e_adv = `SPCL_ADV_RST;
      e_adv[8] = f | v[2];
      e_adv[7] = f | v[2];
   endfunction
   task automatic run_case(input int i);
      logic f;
      logic [2:0] ev;
      logic [15:0] ec;
      f = i[3] && i < 16;
      rstn_i <= 1'b0;
      fib <= f;
      fit <= (i == 16) ? 3'h0 : 3'h7;
      val <= 3'(i);
      repeat (5) @(posedge mclk_i);
      ev = (fit & val) | ~fit;
      ec = e_ctrl(f, ev);
      chk("pull_rst", 16'h0001, {15'h0000, pu});
      rstn_i <= 1'b1;
      if (i % 3 != 0)
      begin
         ce_i <= 1'b0;
         repeat (i % 3) @(posedge mclk_i);
      end
      ce_i <= 1'b1;
      #1 chk("oe_hold", 16'h0000, {13'h0000, oe});
      @(posedge mclk_i);
      #1 chk("oe_run", 16'h0007, {13'h0000, oe});
      chk("pull_run", 16'h0000, {15'h0000, pu});
      for (int k = 0; k < 4; k++)
      begin
         @(posedge mclk_i);
         pin_data <= 3'($random(seed));
         val <= 3'($random(seed));
         fit <= 3'($random(seed));
         @(posedge mclk_i);
         #1 chk("pin_out", {13'h0000, pin_data}, {13'h0000, pin_o});
      end
      rd(`SPCL_REG_CTRL, d);
      chk("ctrl", ec, d);
      @(posedge mclk_i);
      #1 chk("rd_idle", `SPCL_DATA_ZERO, rdata);
      rd(`SPCL_REG_ADV, d);
      chk("adv", e_adv(f, ev), d);
      rd(`SPCL_REG_STRAP, d);
      chk("strap", {13'h0000, 1'b1, f, f ? ev[2] : 1'b1}, d);
      chk("cfg", {11'h000, ec[13], ~ev[1], ~f & ev[0], f ? ev[2] : 1'b1, f},
          {11'h000, cfg});
      w = 16'($random(seed));
      ea = e_adv(f, ev);
      wr(`SPCL_REG_CTRL, w);
      rd(`SPCL_REG_CTRL, d);
      chk("ctrl_wr", w, d);
      wr(`SPCL_REG_ADV, ~ea);
      rd(`SPCL_REG_ADV, d);
      chk("adv_wr", (ea & ~`SPCL_ADV_WMASK) | (~ea & `SPCL_ADV_WMASK), d);
      rd(5'h0a, d);
      chk("unmapped", `SPCL_DATA_ZERO, d);
      $display("test %0d done", i);
   endtask
   task automatic print_verdict;
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // Each case takes well under a hundred cycles; the limit leaves wide margin.
   initial
   begin
      #20000;
      mismatches++;
      print_verdict;
   end
   initial
   begin
      for (int i = 0; i < 17; i++)
         run_case(i);
      print_verdict;
   end
endmodule // testbench
